// ===== lngp_pkg.sv
// Constants for the luma noise-reduction and gamma stage.
// Assumes an 8-bit register port driven by a serial host bridge.
package lngp_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GAMMA_BASE = 8'h26;
    localparam logic [7:0] ADDR_GAMMA_LAST = 8'h32;
    localparam logic [7:0] ADDR_BRIGHT = 8'h34;
    localparam logic [7:0] ADDR_OCLK = 8'h35;
    localparam logic [7:0] ADDR_NR2 = 8'h25;
    localparam logic [7:0] ADDR_CTRL = 8'h36;
    localparam int GAMMA_REGS = 14;
    localparam int CURVE_PTS = 7;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int NR_SEL_LSB = 0;
    localparam int NR_MODE_BIT = 3;
    localparam int NR_OFS_LSB = 4;
    localparam int OCLK_EN_BIT = 1;
    localparam int CTRL_PLL_DIS_BIT = 0;
    localparam int CTRL_OVS_BIT = 1;
    localparam int CTRL_CURVE_B_BIT = 2;
    localparam int CTRL_THRESH_LSB = 0;
    // ------------------------------------------------------------
    // Reset values and fixed curve points
    // ------------------------------------------------------------
    localparam logic [7:0] NR2_RESET = 8'h00;
    localparam logic [7:0] OCLK_RESET = 8'h70;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] THRESH_RESET = 8'h08;
    localparam logic [7:0] GAIN_RESET = 8'h04;
    localparam logic [7:0] PT_LO = 8'h10;
    localparam logic [7:0] PT_HI = 8'hf0;
    localparam logic [7:0] PT_MAX = 8'hff;
    localparam int SEG_SHIFT = 5;
    localparam int FLT_TAPS = 8;
endpackage

// ===== lngp_skid.sv
// Two-entry buffer for the luma output path.
// Assumes one clock domain and synchronous active-low reset.
module lngp_skid #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    logic [WIDTH-1:0] mem_ff [2];
    logic rdPtr_ff, wrPtr_ff;
    logic [1:0] count_ff;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;

    if (WIDTH < 1) begin : g_bad_width
        $error("lngp_skid width");
    end

    assign inReady = (count_ff != 2'd2);
    assign outValid = (count_ff != 2'd0);
    assign outData = mem_ff[rdPtr_ff];

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdPtr_ff <= 1'b0;
            wrPtr_ff <= 1'b0;
            count_ff <= 2'd0;
        end else begin
            if (doWrite) wrPtr_ff <= ~wrPtr_ff;
            if (doRead) rdPtr_ff <= ~rdPtr_ff;
            count_ff <= count_ff + 2'(doWrite) - 2'(doRead);
        end
    end

    always_ff @(posedge clock) begin
        if (doWrite) mem_ff[wrPtr_ff] <= inData;
    end
endmodule

// ===== lngp_gamma.sv
// Piecewise-linear gamma curve on luma.
// Assumes point registers are held stable by the register block.
module lngp_gamma (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Curve points
    input wire logic [7:0] points [7],
    // Sample
    input wire logic [7:0] lumaIn,
    output logic [7:0] lumaOut
);
    logic [7:0] nxt_lumaOut;
    logic [7:0] lumaOut_ff;
    logic [7:0] knotX [11];
    logic [7:0] knotY [11];
    logic [7:0] x0, x1, y0, y1;
    logic signed [17:0] slope;
    logic signed [17:0] interp;

    // Knots: 0,16,32..224,240,255
    always_comb begin
        knotX[0] = 8'h00;
        knotY[0] = 8'h00;
        knotX[1] = lngp_pkg::PT_LO;
        knotY[1] = lngp_pkg::PT_LO;
        for (int i = 0; i < lngp_pkg::CURVE_PTS; i++) begin
            knotX[i+2] = 8'((i + 1) << lngp_pkg::SEG_SHIFT);
            knotY[i+2] = points[i];
        end
        knotX[9] = lngp_pkg::PT_HI;
        knotY[9] = lngp_pkg::PT_HI;
        knotX[10] = lngp_pkg::PT_MAX;
        knotY[10] = lngp_pkg::PT_MAX;
    end

    // Segment search then linear blend
    always_comb begin
        x0 = knotX[0];
        x1 = knotX[1];
        y0 = knotY[0];
        y1 = knotY[1];
        for (int k = 0; k < 10; k++) begin
            if (lumaIn >= knotX[k]) begin
                x0 = knotX[k];
                x1 = knotX[k+1];
                y0 = knotY[k];
                y1 = knotY[k+1];
            end
        end
        slope = (18'(signed'({1'b0, y1})) - 18'(signed'({1'b0, y0})))
            * 18'(signed'({1'b0, lumaIn - x0}));
        interp = 18'(signed'({1'b0, y0}))
            + 18'(slope / 18'(signed'({1'b0, x1 - x0})));
        // Clamp keeps odd curves from wrapping
        if (interp < 0) nxt_lumaOut = 8'h00;
        else if (interp > 18'sd255) nxt_lumaOut = 8'hff;
        else nxt_lumaOut = interp[7:0];
    end

    always_ff @(posedge clock) begin
        if (!reset_n) lumaOut_ff <= 8'h00;
        else lumaOut_ff <= nxt_lumaOut;
    end
    assign lumaOut = lumaOut_ff;
endmodule

// ===== lngp_top.sv
// Luma noise-reduction, gamma and brightness detect stage.
// Assumes registers come over a simple 8-bit port from a host bridge.
module lngp_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Luma in
    input wire logic lumaValid,
    input wire logic [7:0] lumaIn,
    input wire logic [9:0] chromaIn,
    input wire logic activeVideo,
    input wire logic vsync_n,
    output logic lumaReady,
    // Luma out
    output logic outValid,
    output logic [7:0] outLuma,
    output logic [9:0] outChroma,
    input wire logic outReady,
    // Clock output
    input wire logic pllClock,
    output logic clockOutputPin
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] gamma_ff [lngp_pkg::GAMMA_REGS];
    logic [7:0] nr2_ff, oclk_ff, ctrl_ff, thresh_ff, gain_ff;
    logic [7:0] bright_ff;
    logic [31:0] sum_ff;
    logic [23:0] cnt_ff;
    logic vsyncD_ff;
    logic [3:0] pixCnt_ff;
    logic [7:0] hist_ff [lngp_pkg::FLT_TAPS];
    logic [7:0] nrLuma_ff;
    logic nrValid_ff;
    logic [9:0] chroma_ff;
    logic [9:0] chromaD_ff;
    logic gValid_ff;

    wire [7:0] offA = regAddr - lngp_pkg::ADDR_GAMMA_BASE;
    wire hitGamma = (regAddr >= lngp_pkg::ADDR_GAMMA_BASE) &&
        (regAddr <= lngp_pkg::ADDR_GAMMA_LAST);
    wire [2:0] filtSel = nr2_ff[lngp_pkg::NR_SEL_LSB +: 3];
    wire sharpMode = nr2_ff[lngp_pkg::NR_MODE_BIT];
    wire [3:0] blkOfs = nr2_ff[lngp_pkg::NR_OFS_LSB +: 4];
    wire curveB = ctrl_ff[lngp_pkg::CTRL_CURVE_B_BIT];
    wire vsFall = vsyncD_ff && !vsync_n;

    // Gamma bank: 0..6 curve A, 7..13 curve B
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < lngp_pkg::GAMMA_REGS; i++)
                gamma_ff[i] <= 8'(32 * ((i % 7) + 1));
        end else if (regWrite && hitGamma) begin
            gamma_ff[offA[3:0]] <= regWdata;
        end
    end

    // Brightness register is read only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            nr2_ff <= lngp_pkg::NR2_RESET;
            oclk_ff <= lngp_pkg::OCLK_RESET;
            ctrl_ff <= lngp_pkg::CTRL_RESET;
            thresh_ff <= lngp_pkg::THRESH_RESET;
            gain_ff <= lngp_pkg::GAIN_RESET;
        end else if (regWrite) begin
            case (regAddr)
                lngp_pkg::ADDR_NR2: nr2_ff <= regWdata;
                lngp_pkg::ADDR_OCLK: oclk_ff <= regWdata;
                lngp_pkg::ADDR_CTRL: ctrl_ff <= regWdata;
                lngp_pkg::ADDR_CTRL + 8'h01: thresh_ff <= regWdata;
                lngp_pkg::ADDR_CTRL + 8'h02: gain_ff <= regWdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        regRdata = 8'h00;
        if (regRead) begin
            if (hitGamma) regRdata = gamma_ff[offA[3:0]];
            case (regAddr)
                lngp_pkg::ADDR_NR2: regRdata = nr2_ff;
                lngp_pkg::ADDR_BRIGHT: regRdata = bright_ff;
                lngp_pkg::ADDR_OCLK: regRdata = oclk_ff;
                lngp_pkg::ADDR_CTRL: regRdata = ctrl_ff;
                lngp_pkg::ADDR_CTRL + 8'h01: regRdata = thresh_ff;
                lngp_pkg::ADDR_CTRL + 8'h02: regRdata = gain_ff;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Noise reduction
    // ------------------------------------------------------------
    // Band split: high pass of growing width per selector value
    function automatic logic signed [9:0] hp(input logic [7:0] cur,
            input logic [7:0] past);
        hp = 10'(signed'({2'b00, cur})) - 10'(signed'({2'b00, past}));
    endfunction

    wire accept = lumaValid && lumaReady;
    wire [2:0] tap = (filtSel == 3'd0) ? 3'd0 : filtSel - 3'd1;
    wire signed [9:0] band = (filtSel == 3'd0) ? 10'sd0 :
        hp(lumaIn, hist_ff[tap]);
    wire [9:0] bandAbs = band[9] ? 10'(-band) : band;
    // Block offset shifts border position
    wire border = (4'(pixCnt_ff + blkOfs) == 4'd0);
    wire [3:0] gainUse = border ? gain_ff[3:0] : gain_ff[7:4];
    wire signed [13:0] scaled = 14'(band) * 14'(signed'({1'b0, gainUse}));
    wire signed [13:0] frac3 = scaled >>> 3;
    wire signed [13:0] frac4 = scaled >>> 4;
    wire below = bandAbs < {2'b00, thresh_ff};
    wire signed [13:0] base = 14'(signed'({6'h00, lumaIn}));
    logic signed [13:0] nrSum;
    always_comb begin
        nrSum = base;
        if (!sharpMode && below) nrSum = base - frac3;
        else if (sharpMode && !below) nrSum = base + frac4;
    end
    wire [7:0] nrClamp = nrSum < 0 ? 8'h00 :
        (nrSum > 14'sd255 ? 8'hff : nrSum[7:0]);

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            for (int i = 0; i < lngp_pkg::FLT_TAPS; i++) hist_ff[i] <= 8'h00;
            pixCnt_ff <= 4'h0;
            nrLuma_ff <= 8'h00;
            nrValid_ff <= 1'b0;
            chroma_ff <= 10'h000;
        end else begin
            nrValid_ff <= accept;
            if (accept) begin
                hist_ff[0] <= lumaIn;
                for (int i = 1; i < lngp_pkg::FLT_TAPS; i++)
                    hist_ff[i] <= hist_ff[i-1];
                pixCnt_ff <= activeVideo ? pixCnt_ff + 4'h1 : 4'h0;
                nrLuma_ff <= nrClamp;
                chroma_ff <= chromaIn;
            end
        end
    end

    // ------------------------------------------------------------
    // Gamma and output buffer
    // ------------------------------------------------------------
    logic [7:0] curve [7];
    logic [7:0] gOut;
    logic bufReady;
    always_comb begin
        for (int i = 0; i < lngp_pkg::CURVE_PTS; i++)
            curve[i] = gamma_ff[curveB ? i + 7 : i];
    end
    lngp_gamma u_gamma (
        .clock(clock),
        .reset_n(reset_n),
        .points(curve),
        .lumaIn(nrLuma_ff),
        .lumaOut(gOut)
    );
    // Words in flight plus buffered never exceed the buffer depth,
    // so a stalled sink cannot strand a word in the gamma stage
    logic [1:0] occ_ff;
    wire drainOut = outValid && outReady;
    always_ff @(posedge clock) begin
        if (!reset_n) occ_ff <= 2'd0;
        else occ_ff <= occ_ff + 2'(accept) - 2'(drainOut);
    end
    assign lumaReady = bufReady && (occ_ff != 2'd2);
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            gValid_ff <= 1'b0;
            chromaD_ff <= 10'h000;
        end else begin
            gValid_ff <= nrValid_ff;
            chromaD_ff <= chroma_ff; // Chroma bypasses gamma
        end
    end
    lngp_skid #(.WIDTH(18)) u_buf (
        .clock(clock),
        .reset_n(reset_n),
        .inValid(gValid_ff),
        .inData({chromaD_ff, gOut}),
        .inReady(bufReady),
        .outValid(outValid),
        .outData({outChroma, outLuma}),
        .outReady(outReady)
    );

    // ------------------------------------------------------------
    // Brightness detect
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            vsyncD_ff <= 1'b1;
            sum_ff <= 32'h0;
            cnt_ff <= 24'h0;
            bright_ff <= 8'h00;
        end else begin
            vsyncD_ff <= vsync_n;
            if (vsFall) begin
                bright_ff <= (cnt_ff == 24'h0) ? 8'h00 :
                    8'(sum_ff / {8'h00, cnt_ff});
                sum_ff <= 32'h0;
                cnt_ff <= 24'h0;
            end else if (accept && activeVideo) begin
                sum_ff <= sum_ff + {24'h0, lumaIn};
                cnt_ff <= cnt_ff + 24'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock output gate
    // ------------------------------------------------------------
    // Gate level is registered; pin is combinational with pll clock
    logic clkGate_ff;
    always_ff @(posedge clock) begin
        if (!reset_n) clkGate_ff <= 1'b0;
        else clkGate_ff <= oclk_ff[lngp_pkg::OCLK_EN_BIT] &&
            !ctrl_ff[lngp_pkg::CTRL_PLL_DIS_BIT] &&
            ctrl_ff[lngp_pkg::CTRL_OVS_BIT];
    end
    assign clockOutputPin = pllClock & clkGate_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_bright_update;
        @(posedge clock) disable iff (!reset_n)
        !vsFall |=> $stable(bright_ff);
    endproperty
    a_bright_update: assert property (p_bright_update)
        else $error("brightness changed off vsync");
    property p_clk_gate;
        @(posedge clock) disable iff (!reset_n)
        ctrl_ff[lngp_pkg::CTRL_PLL_DIS_BIT] |=> !clkGate_ff;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("clock out with pll off");
    property p_nr_passthru;
        @(posedge clock) disable iff (!reset_n)
        (filtSel == 3'd0) |-> nrClamp == lumaIn;
    endproperty
    a_nr_passthru: assert property (p_nr_passthru)
        else $error("nr altered with no filter");
    property p_sharp_above;
        @(posedge clock) disable iff (!reset_n)
        (sharpMode && below) |-> nrClamp == lumaIn;
    endproperty
    a_sharp_above: assert property (p_sharp_above)
        else $error("sharpening touched sub threshold");
    property p_plain_below;
        @(posedge clock) disable iff (!reset_n)
        (!sharpMode && !below) |-> nrClamp == lumaIn;
    endproperty
    a_plain_below: assert property (p_plain_below)
        else $error("plain mode touched above threshold");
    property p_bright_ro;
        @(posedge clock) disable iff (!reset_n)
        (regWrite && regAddr == lngp_pkg::ADDR_BRIGHT && !vsFall)
            |=> $stable(bright_ff);
    endproperty
    a_bright_ro: assert property (p_bright_ro)
        else $error("brightness written");
    sequence s_take;
        accept;
    endsequence
    property p_chroma;
        @(posedge clock) disable iff (!reset_n)
        s_take |=> ##1 (chromaD_ff == $past(chromaIn, 2));
    endproperty
    a_chroma: assert property (p_chroma)
        else $error("chroma altered");
    property p_clk_en;
        @(posedge clock) disable iff (!reset_n)
        (!oclk_ff[lngp_pkg::OCLK_EN_BIT]) |=> !clkGate_ff;
    endproperty
    a_clk_en: assert property (p_clk_en)
        else $error("clock out while disabled");
    property p_clk_ovs;
        @(posedge clock) disable iff (!reset_n)
        (!ctrl_ff[lngp_pkg::CTRL_OVS_BIT]) |=> !clkGate_ff;
    endproperty
    a_clk_ovs: assert property (p_clk_ovs)
        else $error("clock out without oversampling");
    sequence s_vs_fall;
        vsyncD_ff && !vsync_n;
    endsequence
    property p_vs_restart;
        @(posedge clock) disable iff (!reset_n)
        s_vs_fall |=> (cnt_ff == 24'h0) && (sum_ff == 32'h0);
    endproperty
    a_vs_restart: assert property (p_vs_restart)
        else $error("accumulator kept across vsync");
    property p_blank_skip;
        @(posedge clock) disable iff (!reset_n)
        (!(accept && activeVideo) && !vsFall) |=> $stable(cnt_ff);
    endproperty
    a_blank_skip: assert property (p_blank_skip)
        else $error("blanking sample counted");
    property p_gamma_ends;
        @(posedge clock) disable iff (!reset_n)
        (nrLuma_ff == lngp_pkg::PT_LO) || (nrLuma_ff == lngp_pkg::PT_HI)
            |=> gOut == $past(nrLuma_ff);
    endproperty
    a_gamma_ends: assert property (p_gamma_ends)
        else $error("fixed curve point moved");
    property p_gamma_rails;
        @(posedge clock) disable iff (!reset_n)
        (nrLuma_ff == 8'h00) || (nrLuma_ff == lngp_pkg::PT_MAX)
            |=> gOut == $past(nrLuma_ff);
    endproperty
    a_gamma_rails: assert property (p_gamma_rails)
        else $error("range end not passed through");
    property p_blank_ofs;
        @(posedge clock) disable iff (!reset_n)
        (accept && !activeVideo) |=> pixCnt_ff == 4'h0;
    endproperty
    a_blank_ofs: assert property (p_blank_ofs)
        else $error("pixel count kept through blanking");
    // Occupancy limit must keep the buffer from ever refusing a word
    property p_no_overflow;
        @(posedge clock) disable iff (!reset_n)
        gValid_ff |-> bufReady;
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("word pushed into full buffer");
endmodule

// ===== lngp_video_src.sv
// Upstream luma source model for the luma stage bench.
// Assumes the sink samples its handshake on the rising clock edge.
module lngp_video_src (
    // Clock
    input wire logic clock,
    // Stream
    output logic lumaValid,
    output logic [7:0] lumaIn,
    output logic [9:0] chromaIn,
    output logic activeVideo,
    output logic vsync_n,
    input wire logic lumaReady
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        lumaValid = 1'b0;
        lumaIn = 8'h00;
        chromaIn = 10'h000;
        activeVideo = 1'b0;
        vsync_n = 1'b1;
    end
    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    // Held until taken; ok is low if the sink has not taken it within 49 clocks
    task automatic send(input logic [7:0] y, input logic [9:0] c,
                        input logic act, output bit ok);
        int n;
        n = 0;
        lumaValid = 1'b1;
        lumaIn = y;
        chromaIn = c;
        activeVideo = act;
        do begin
            @(posedge clock);
            n++;
        end while (lumaReady !== 1'b1 && n < 50);
        ok = (n < 50);
        #1;
    endtask
    // Released lines show no stale sample
    task automatic release_bus();
        lumaValid = 1'b0;
        lumaIn = ~lumaIn;
        chromaIn = ~chromaIn;
        @(posedge clock);
        #1;
    endtask
    task automatic vsync_pulse();
        vsync_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        vsync_n = 1'b1;
        @(posedge clock);
        #1;
    endtask
endmodule

// ===== luma_noise_gamma_processing_tb.sv
// Self-checking bench for the luma noise, gamma and brightness stage.
// Assumes lngp_pkg and the source model are compiled first.
module luma_noise_gamma_processing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock, reset_n, regWrite, regRead, outReady, pllClock;
    logic [7:0] regAddr, regWdata, regRdata, outLuma, lumaIn, my;
    logic lumaValid, activeVideo, vsync_n, lumaReady, outValid;
    logic [9:0] chromaIn, outChroma, mc;
    logic clockOutputPin;
    int failures, check_count, pts[7], mk, seed, v;
    logic [7:0] expY[$];
    logic [9:0] expC[$];
    int expK[$];
    logic [7:0] ra[5] = '{8'h25, 8'h35, 8'h36, 8'h37, 8'h38};
    logic [7:0] rv[5] = '{8'h00, 8'h70, 8'h00, 8'h08, 8'h04};
    logic [7:0] fx[4] = '{8'h00, 8'h10, 8'hf0, 8'hff};
    lngp_top i_lngp_top (.clock, .reset_n, .regWrite, .regRead,
        .regAddr, .regWdata, .regRdata, .lumaValid, .lumaIn,
        .chromaIn, .activeVideo, .vsync_n, .lumaReady, .outValid,
        .outLuma, .outChroma, .outReady, .pllClock, .clockOutputPin);
    lngp_video_src i_lngp_video_src (.clock, .lumaValid, .lumaIn,
        .chromaIn, .activeVideo, .vsync_n, .lumaReady);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        pllClock = 1'b0;
        forever #9.259 pllClock = ~pllClock;
    end
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic ok, input logic [9:0] e,
                         input logic [9:0] g);
        check_count++;
        if (ok !== 1'b1) begin
            failures++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic timeout();
        failures++;
        stop_test();
    endtask
    // Midpoints are exact because every programmed point is even
    function automatic logic [7:0] gam(input int j);
        if (j % 2 == 0)
            return 8'(pts[j / 2]);
        return 8'((pts[j / 2] + pts[j / 2 + 1]) / 2);
    endfunction
    always @(posedge clock) begin
        if (outValid === 1'b1 && outReady === 1'b1) begin
            if (expY.size() == 0) begin
                check(1'b0, 10'h000, outLuma);
            end else begin
                my = expY.pop_front();
                mc = expC.pop_front();
                mk = expK.pop_front();
                check(outChroma === mc, mc, outChroma);
                if (mk == 0)
                    check(outLuma === my, my, outLuma);
                if (mk == 1)
                    check(outLuma < my, my, outLuma);
                if (mk == 2)
                    check(outLuma > my, my, outLuma);
            end
        end
    end
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clock);
        #1;
        regWrite = 1'b0;
        regWdata = ~d;
        @(posedge clock);
        #1;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        regRead = 1'b1;
        regAddr = a;
        @(posedge clock);
        check(regRdata === e, e, regRdata);
        #1;
        regRead = 1'b0;
        @(posedge clock);
        #1;
    endtask
    // Kind 0 exact, 1 below, 2 above, 3 luma not judged
    task automatic put(input logic [7:0] y, input logic [7:0] e,
                       input int k, input logic act);
        logic [9:0] c;
        bit ok;
        c = 10'($urandom);
        expY.push_back(e);
        expC.push_back(c);
        expK.push_back(k);
        i_lngp_video_src.send(y, c, act, ok);
        if (!ok)
            timeout();
    endtask
    task automatic drain();
        i_lngp_video_src.release_bus();
        for (int n = 0; n < 100 && expY.size() > 0; n++)
            @(posedge clock);
        if (expY.size() > 0)
            timeout();
        #1;
    endtask
    task automatic gstream(input int cnt);
        int j;
        for (int i = 0; i < cnt; i++) begin
            j = $urandom_range(12);
            put(8'(32 + 16 * j), gam(j), 0, 1'b0);
        end
        foreach (fx[i])
            put(fx[i], fx[i], 0, 1'b0);
        drain();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        seed = $urandom(74);
        reset_n = 1'b0;
        {regWrite, regRead, regAddr, regWdata} = '0;
        outReady = 1'b1;
        repeat (12) @(posedge clock);
        #1;
        reset_n = 1'b1;
        foreach (ra[i])
            rdchk(ra[i], rv[i]);
        for (int k = 0; k < 14; k++)
            rdchk(8'(38 + k), (k == 13) ? 8'h00 : 8'(32 * (k % 7 + 1)));
        rdchk(8'h40, 8'h00);
        for (int k = 0; k < 7; k++) begin
            pts[k] = 16 + 2 * $urandom_range(112);
            wr(8'(38 + k), 8'(pts[k]));
            rdchk(8'(38 + k), 8'(pts[k]));
        end
        // Zero gains so only the curve shapes the output
        wr(8'h38, 8'h00);
        gstream(40);
        for (int k = 0; k < 6; k++) begin
            pts[k] = 16 + 2 * $urandom_range(112);
            wr(8'(45 + k), 8'(pts[k]));
        end
        pts[6] = 224;
        wr(8'h36, 8'h04);
        gstream(40);
        // Stalled sink: two words fill the buffer, none lost
        outReady = 1'b0;
        put(8'h20, gam(0), 0, 1'b0);
        put(8'h40, gam(2), 0, 1'b0);
        i_lngp_video_src.release_bus();
        for (int n = 0; n < 10 && lumaReady !== 1'b0; n++)
            @(posedge clock);
        check(lumaReady === 1'b0, 10'h000, lumaReady);
        #1;
        outReady = 1'b1;
        drain();
        for (int k = 0; k < 7; k++) begin
            pts[k] = 32 * (k + 1);
            wr(8'(38 + k), 8'(pts[k]));
        end
        wr(8'h36, 8'h00);
        wr(8'h38, 8'hff);
        for (int s = 1; s < 8; s++) begin
            for (int m = 0; m < 2; m++) begin
                v = ((2 * s + m) << 4) | (m << 3) | s;
                wr(8'h25, 8'(v));
                rdchk(8'h25, 8'(v));
                repeat (10) put(8'd100, 8'd100, 3, 1'b0);
                repeat (2) put(8'd100, 8'd100, 0, 1'b0);
                put(m ? 8'd140 : 8'd104, m ? 8'd140 : 8'd104, m + 1,
                    1'b0);
                drain();
            end
        end
        wr(8'h38, 8'h00);
        i_lngp_video_src.vsync_pulse();
        repeat (3) @(posedge clock);
        #1;
        rdchk(8'h34, 8'h00);
        for (int i = 0; i < 12; i++)
            put((i % 3) ? 8'd80 : 8'd200, (i % 3) ? 8'd80 : 8'd200, 0,
                (i % 3) != 0);
        drain();
        rdchk(8'h34, 8'h00);
        i_lngp_video_src.vsync_pulse();
        repeat (3) @(posedge clock);
        #1;
        rdchk(8'h34, 8'd80);
        wr(8'h34, 8'h55);
        rdchk(8'h34, 8'd80);
        for (int c = 0; c < 8; c++) begin
            wr(8'h36, 8'(c & 3));
            wr(8'h35, (c & 4) ? 8'h72 : 8'h70);
            repeat (3) @(posedge clock);
            for (int i = 0; i < 6; i++) begin
                #($urandom_range(7) + 0.5);
                check(clockOutputPin === ((c == 6) ? pllClock : 1'b0),
                    pllClock, clockOutputPin);
            end
            @(posedge clock);
            #1;
        end
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge clock);
        timeout();
    end
endmodule
